// >>> ppp_port.sv
// Purpose: Parallel high-voltage programming port: pin decode, loading, page buffer, sequencing.
// Assumes: Memory arrays sit behind a request/acknowledge port; fuse values are inputs.
// Notes:   Every pin is synchronised, so pulses must span several clock periods.
`timescale 1ns/1ps
module ppp_port
    import ppp_pkg::*;
#(
    parameter int unsigned FWB = ppp_pkg::FLASH_WORD_BITS,
    parameter int unsigned EWB = ppp_pkg::EE_BYTE_BITS
) (
    input  wire logic                  CLK_I,
    input  wire logic                  NRST_I,
    input  wire logic                  HV_RESET_I,
    input  wire logic                  STROBE_CLK_I,
    input  wire logic                  WRITE_STROBE_N_I,
    input  wire logic                  OUTPUT_ENABLE_N_I,
    input  wire logic                  PAGE_LATCH_I,
    input  wire logic                  STROBE_ACTION_BIT0_I,
    input  wire logic                  STROBE_ACTION_BIT1_I,
    input  wire logic                  BYTE_SELECT_LO_BIT_I,
    input  wire logic                  BYTE_SELECT_HI_BIT_I,
    input  wire logic [7:0]            DATA_I,
    output logic      [7:0]            DATA_O,
    output logic                       DATA_OE_O,
    output logic                       READY_BUSY_FLAG_O,
    output logic                       PROG_MODE_O,
    input  wire logic [7:0]            FUSE_LOW_I,
    input  wire logic [7:0]            FUSE_HIGH_I,
    input  wire logic [7:0]            FUSE_EXT_I,
    input  wire logic [7:0]            LOCK_I,
    input  wire logic                  KEEP_EEPROM_FUSE_I,
    output logic                       NVM_REQ_O,
    output ppp_pkg::ppp_nvm_req_t      NVM_CMD_O,
    input  wire logic                  NVM_ACK_I,
    input  wire logic [15:0]           NVM_RDATA_I
);

    import ppp_pkg::*;

    typedef enum logic [6:0] {
        S_IDLE     = 7'b0000001,
        S_ERASE_FL = 7'b0000010,
        S_ERASE_EE = 7'b0000100,
        S_ERASE_LK = 7'b0001000,
        S_PROG_RD  = 7'b0010000,
        S_PROG_WR  = 7'b0100000,
        S_SINGLE   = 7'b1000000
    } ppp_state_t;

    ppp_pins_t           pins_raw;
    ppp_pins_t           pins;
    ppp_pins_t           pins_q;
    ppp_state_t          state;
    logic                strobe_rise;
    logic                wr_fall;
    logic                oe_fall;
    logic                latch_rise;
    logic                hv_rise;
    logic [3:0]          entry_pat;
    logic                entry_check;
    logic [3:0]          entry_cnt;
    logic [7:0]          cmd;
    logic [23:0]         addr;
    logic [7:0]          data_lo;
    logic [7:0]          data_hi;
    logic                session;
    logic                buf_we;
    logic [FWB-1:0]      buf_waddr;
    logic [15:0]         buf_wdata;
    logic [FWB-1:0]      prog_idx;
    logic                prog_ee;
    logic [15:0]         buf_rdata;
    logic                rd_pend;
    logic [15:0]         rd_word;
    logic [7:0]          next_data;

    function automatic logic is_read_cmd(input logic [7:0] c);
        is_read_cmd = (c == CMD_READ_FLASH) || (c == CMD_READ_EE) || (c == CMD_READ_SIG);
    endfunction

    function automatic logic [FWB-1:0] buf_index(input logic ee, input logic [23:0] a);
        logic [FWB-1:0] idx;
        idx = '0;
        if (ee) begin
            idx[EWB-1:0] = a[EWB-1:0];
        end else begin
            idx = a[FWB-1:0];
        end
        buf_index = idx;
    endfunction

    assign pins_raw = '{hv: HV_RESET_I, strobe_clk: STROBE_CLK_I, wr_n: WRITE_STROBE_N_I,
                        oe_n: OUTPUT_ENABLE_N_I, page_latch: PAGE_LATCH_I,
                        xa: {STROBE_ACTION_BIT1_I, STROBE_ACTION_BIT0_I},
                        bs: {BYTE_SELECT_HI_BIT_I, BYTE_SELECT_LO_BIT_I}, data: DATA_I};

    ppp_sync #(
        .W    ($bits(ppp_pins_t)),
        .INIT (PINS_IDLE)
    ) u_sync (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .d_i    (pins_raw),
        .q_o    (pins)
    );

    // Edges are taken from the synchronised copy; any pulse wider than two clock periods
    // is caught, which covers the minimum pulse width with margin.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pins_q <= PINS_IDLE;
        end else begin
            pins_q <= pins;
        end
    end

    assign strobe_rise = PROG_MODE_O && pins.strobe_clk && !pins_q.strobe_clk;
    assign wr_fall     = PROG_MODE_O && !pins.wr_n && pins_q.wr_n;
    assign oe_fall     = PROG_MODE_O && !pins.oe_n && pins_q.oe_n;
    assign latch_rise  = PROG_MODE_O && pins.page_latch && !pins_q.page_latch;
    assign hv_rise     = pins.hv && !pins_q.hv;
    assign entry_pat   = {pins.page_latch, pins.xa, pins.bs[0]};

    // Entry: the pattern must be zero when high voltage arrives and stay so for the hold time.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PROG_MODE_O <= 1'b0;
            entry_check <= 1'b0;
            entry_cnt   <= 4'h0;
        end else if (!pins.hv) begin
            PROG_MODE_O <= 1'b0;
            entry_check <= 1'b0;
            entry_cnt   <= 4'h0;
        end else if (hv_rise) begin
            entry_check <= (entry_pat == 4'h0);
            entry_cnt   <= 4'h0;
        end else if (entry_check) begin
            if (entry_pat != 4'h0) begin
                entry_check <= 1'b0;
            end else if (entry_cnt == ENTRY_HOLD_CYC - 4'h1) begin
                entry_check <= 1'b0;
                PROG_MODE_O <= 1'b1;
            end else begin
                entry_cnt <= entry_cnt + 4'h1;
            end
        end
    end

    // Command, address and data bytes persist until overwritten.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cmd     <= CMD_NOP;
            addr    <= ADDR_RESET;
            data_lo <= BYTE_RESET;
            data_hi <= BYTE_RESET;
        end else if (strobe_rise) begin
            case (pins.xa)
                ACT_ADDR: begin
                    case (pins.bs)
                        SEL_LOW:  addr[7:0]   <= pins.data;
                        SEL_HIGH: addr[15:8]  <= pins.data;
                        SEL_EXT:  addr[23:16] <= pins.data;
                        default:  addr        <= addr;
                    endcase
                end
                ACT_DATA: begin
                    if (pins.bs[0]) begin
                        data_hi <= pins.data;
                    end else begin
                        data_lo <= pins.data;
                    end
                end
                ACT_CMD: begin
                    cmd <= pins.data;
                end
                default: begin
                    cmd <= cmd;
                end
            endcase
        end
    end

    // A page session opens with the first latched word and closes on the no-operation command.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            session <= 1'b0;
        end else if (buf_we) begin
            session <= 1'b1;
        end else if (strobe_rise && pins.xa == ACT_CMD && pins.data == CMD_NOP) begin
            session <= 1'b0;
        end
    end

    assign buf_we    = latch_rise && session_ok();
    assign buf_waddr = buf_index(cmd == CMD_WRITE_EE, addr);
    assign buf_wdata = {data_hi, data_lo};

    function automatic logic session_ok();
        session_ok = (cmd == CMD_WRITE_FLASH) || (cmd == CMD_WRITE_EE);
    endfunction

    ppp_page_buf #(
        .AW (FWB),
        .DW (16)
    ) u_buf (
        .clk_i   (CLK_I),
        .we_i    (buf_we),
        .waddr_i (buf_waddr),
        .wdata_i (buf_wdata),
        .raddr_i (prog_idx),
        .rdata_o (buf_rdata)
    );

    // Operation sequencer and memory request port.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state     <= S_IDLE;
            NVM_REQ_O <= 1'b0;
            NVM_CMD_O <= '{op: NVM_NOP, sel: SEL_LOW, addr: ADDR_RESET, wdata: 16'h0000};
            prog_idx  <= '0;
            prog_ee   <= 1'b0;
            rd_pend   <= 1'b0;
            rd_word   <= 16'hffff;
        end else begin
            case (state)
                S_IDLE: begin
                    if (rd_pend) begin
                        if (NVM_ACK_I) begin
                            NVM_REQ_O <= 1'b0;
                            rd_pend   <= 1'b0;
                            rd_word   <= NVM_RDATA_I;
                        end
                    end else if (wr_fall) begin
                        case (cmd)
                            CMD_CHIP_ERASE: begin
                                state <= S_ERASE_FL;
                            end
                            CMD_WRITE_FLASH, CMD_WRITE_EE: begin
                                if (pins.bs == SEL_LOW && session) begin
                                    prog_ee  <= (cmd == CMD_WRITE_EE);
                                    prog_idx <= '0;
                                    state    <= S_PROG_RD;
                                end
                            end
                            CMD_WRITE_FUSE, CMD_WRITE_LOCK: begin
                                NVM_REQ_O <= 1'b1;
                                NVM_CMD_O <= '{op: (cmd == CMD_WRITE_FUSE) ? NVM_WRITE_FUSE
                                                                           : NVM_WRITE_LOCK,
                                               sel: pins.bs, addr: addr,
                                               wdata: {8'h00, data_lo}};
                                state     <= S_SINGLE;
                            end
                            default: begin
                                state <= S_IDLE;
                            end
                        endcase
                    end else if (oe_fall && is_read_cmd(cmd)) begin
                        NVM_REQ_O <= 1'b1;
                        rd_pend   <= 1'b1;
                        NVM_CMD_O <= '{op: (cmd == CMD_READ_FLASH) ? NVM_READ_FLASH :
                                           (cmd == CMD_READ_EE) ? NVM_READ_EE : NVM_READ_SIG,
                                       sel: pins.bs, addr: addr, wdata: 16'h0000};
                    end
                end
                S_ERASE_FL: begin
                    if (!NVM_REQ_O) begin
                        NVM_REQ_O <= 1'b1;
                        NVM_CMD_O <= '{op: NVM_ERASE_FLASH, sel: SEL_LOW, addr: addr,
                                       wdata: 16'hffff};
                    end else if (NVM_ACK_I) begin
                        NVM_REQ_O <= 1'b0;
                        state     <= KEEP_EEPROM_FUSE_I ? S_ERASE_LK : S_ERASE_EE;
                    end
                end
                S_ERASE_EE: begin
                    if (!NVM_REQ_O) begin
                        NVM_REQ_O <= 1'b1;
                        NVM_CMD_O <= '{op: NVM_ERASE_EE, sel: SEL_LOW, addr: addr,
                                       wdata: 16'hffff};
                    end else if (NVM_ACK_I) begin
                        NVM_REQ_O <= 1'b0;
                        state     <= S_ERASE_LK;
                    end
                end
                S_ERASE_LK: begin
                    // Reached only after the flash erase has been acknowledged.
                    if (!NVM_REQ_O) begin
                        NVM_REQ_O <= 1'b1;
                        NVM_CMD_O <= '{op: NVM_CLEAR_LOCK, sel: SEL_LOW, addr: addr,
                                       wdata: 16'hffff};
                    end else if (NVM_ACK_I) begin
                        NVM_REQ_O <= 1'b0;
                        state     <= S_IDLE;
                    end
                end
                S_PROG_RD: begin
                    state <= S_PROG_WR;
                end
                S_PROG_WR: begin
                    if (!NVM_REQ_O) begin
                        NVM_REQ_O <= 1'b1;
                        if (prog_ee) begin
                            NVM_CMD_O <= '{op: NVM_WRITE_EE, sel: SEL_LOW,
                                           addr: {addr[23:EWB], prog_idx[EWB-1:0]},
                                           wdata: {8'h00, buf_rdata[7:0]}};
                        end else begin
                            NVM_CMD_O <= '{op: NVM_WRITE_FLASH, sel: SEL_LOW,
                                           addr: {addr[23:FWB], prog_idx},
                                           wdata: buf_rdata};
                        end
                    end else if (NVM_ACK_I) begin
                        NVM_REQ_O <= 1'b0;
                        if ((prog_ee && prog_idx == FWB'((1 << EWB) - 1)) ||
                            (!prog_ee && prog_idx == FWB'((1 << FWB) - 1))) begin
                            state <= S_IDLE;
                        end else begin
                            prog_idx <= prog_idx + FWB'(1);
                            state    <= S_PROG_RD;
                        end
                    end
                end
                S_SINGLE: begin
                    if (NVM_ACK_I) begin
                        NVM_REQ_O <= 1'b0;
                        state     <= S_IDLE;
                    end
                end
                default: begin
                    NVM_REQ_O <= 1'b0;
                    state     <= S_IDLE;
                end
            endcase
            // A write strobe outside S_IDLE falls through every branch above unused.
            if (state != S_IDLE && wr_fall) begin
                prog_ee <= prog_ee;
            end
        end
    end

    // Ready flag is derived from the sequencer state; only a chip-erase strobe drops it on the edge that starts work, other writes one edge later.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            READY_BUSY_FLAG_O <= 1'b1;
        end else begin
            READY_BUSY_FLAG_O <= (state == S_IDLE) && !(wr_fall && cmd == CMD_CHIP_ERASE);
        end
    end

    // Read data mux; fuse and lock values come straight from the fuse store.
    always_comb begin
        next_data = rd_word[7:0];
        case (cmd)
            CMD_READ_FUSE: begin
                case (pins.bs)
                    FRD_FUSE_LOW:  next_data = FUSE_LOW_I;
                    FRD_LOCK:      next_data = LOCK_I;
                    FRD_FUSE_EXT:  next_data = FUSE_EXT_I;
                    default:       next_data = FUSE_HIGH_I;
                endcase
            end
            CMD_READ_FLASH, CMD_READ_SIG: begin
                next_data = pins.bs[0] ? rd_word[15:8] : rd_word[7:0];
            end
            default: begin
                next_data = rd_word[7:0];
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            DATA_O    <= 8'h00;
            DATA_OE_O <= 1'b0;
        end else begin
            DATA_O    <= next_data;
            DATA_OE_O <= PROG_MODE_O && !pins.oe_n;
        end
    end

endmodule // ppp_port

// >>> ppp_pkg.sv
// Purpose: Shared constants and types for the parallel programming port.
// Assumes: One 25 MHz clock; all pin inputs are resynchronised before use.
// Notes:   Command, action and select codes are the pin-level encodings.
package ppp_pkg;

    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned ENTRY_HOLD_NS = 100;
    localparam int unsigned ENTRY_HOLD_CYC_INT = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  ENTRY_HOLD_CYC = ENTRY_HOLD_CYC_INT[3:0];
    localparam int unsigned PULSE_MIN_NS = 250;

    localparam logic [1:0] ACT_ADDR = 2'b00;
    localparam logic [1:0] ACT_DATA = 2'b01;
    localparam logic [1:0] ACT_CMD  = 2'b10;
    localparam logic [1:0] ACT_IDLE = 2'b11;

    localparam logic [1:0] SEL_LOW  = 2'b00;
    localparam logic [1:0] SEL_HIGH = 2'b01;
    localparam logic [1:0] SEL_EXT  = 2'b10;
    localparam logic [1:0] SEL_RSVD = 2'b11;

    localparam logic [1:0] FRD_FUSE_LOW  = 2'b00;
    localparam logic [1:0] FRD_LOCK      = 2'b01;
    localparam logic [1:0] FRD_FUSE_EXT  = 2'b10;
    localparam logic [1:0] FRD_FUSE_HIGH = 2'b11;

    localparam logic [7:0] CMD_NOP         = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE  = 8'h80;
    localparam logic [7:0] CMD_WRITE_FUSE  = 8'h40;
    localparam logic [7:0] CMD_WRITE_LOCK  = 8'h20;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] CMD_WRITE_EE    = 8'h11;
    localparam logic [7:0] CMD_READ_SIG    = 8'h08;
    localparam logic [7:0] CMD_READ_FUSE   = 8'h04;
    localparam logic [7:0] CMD_READ_FLASH  = 8'h02;
    localparam logic [7:0] CMD_READ_EE     = 8'h03;

    localparam int unsigned FLASH_WORD_BITS = 7;
    localparam int unsigned EE_BYTE_BITS    = 3;
    localparam logic [23:0] ADDR_RESET      = 24'h000000;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;

    typedef enum logic [3:0] {
        NVM_NOP         = 4'h0,
        NVM_ERASE_FLASH = 4'h1,
        NVM_ERASE_EE    = 4'h2,
        NVM_CLEAR_LOCK  = 4'h3,
        NVM_WRITE_FLASH = 4'h4,
        NVM_WRITE_EE    = 4'h5,
        NVM_WRITE_FUSE  = 4'h6,
        NVM_WRITE_LOCK  = 4'h7,
        NVM_READ_FLASH  = 4'h8,
        NVM_READ_EE     = 4'h9,
        NVM_READ_SIG    = 4'ha
    } ppp_nvm_op_t;

    typedef struct packed {
        ppp_nvm_op_t op;
        logic [1:0]  sel;
        logic [23:0] addr;
        logic [15:0] wdata;
    } ppp_nvm_req_t;

    typedef struct packed {
        logic       hv;
        logic       strobe_clk;
        logic       wr_n;
        logic       oe_n;
        logic       page_latch;
        logic [1:0] xa;
        logic [1:0] bs;
        logic [7:0] data;
    } ppp_pins_t;

    localparam ppp_pins_t PINS_IDLE = '{hv: 1'b0, strobe_clk: 1'b0, wr_n: 1'b1, oe_n: 1'b1,
                                        page_latch: 1'b0, xa: 2'b11, bs: 2'b00, data: 8'h00};

endpackage : ppp_pkg

// >>> ppp_sync.sv
// Purpose: Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes: Bits are independent levels; multi-bit skew is settled by the strobes.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps
module ppp_sync #(
    parameter int unsigned     W    = 1,
    parameter logic [W-1:0]    INIT = '0
) (
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    input  wire logic [W-1:0]  d_i,
    output logic      [W-1:0]  q_o
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= INIT;
            q_o  <= INIT;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule // ppp_sync

// >>> ppp_page_buf.sv
// Purpose: Page buffer memory with one write port and a registered read port.
// Assumes: Single clock; read data appear one edge after the address.
// Notes:   Contents are not reset; only filled entries are meaningful.
`timescale 1ns/1ps
module ppp_page_buf #(
    parameter int unsigned AW = 7,
    parameter int unsigned DW = 16
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule // ppp_page_buf

// >>> ppp_port_monitor.sv
// Purpose: Concurrent checks on the programming port.
// Assumes: Pin pulses last at least 250 ns.
// Notes:   Bounds allow for the two-flop pin synchronisers.
`timescale 1ns/1ps
module ppp_port_monitor (
    input wire logic                  CLK_I,
    input wire logic                  NRST_I,
    input wire logic                  WRITE_STROBE_N_I,
    input wire logic                  OUTPUT_ENABLE_N_I,
    input wire logic                  KEEP_EEPROM_FUSE_I,
    input wire logic                  DATA_OE_O,
    input wire logic                  READY_BUSY_FLAG_O,
    input wire logic                  PROG_MODE_O,
    input wire logic                  NVM_REQ_O,
    input wire ppp_pkg::ppp_nvm_req_t NVM_CMD_O,
    input wire logic                  NVM_ACK_I
);
    import ppp_pkg::*;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    ppp_nvm_op_t last_op;
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) last_op <= NVM_NOP;
        else if (NVM_ACK_I) last_op <= NVM_CMD_O.op;
    end
    sequence s_next; ##[1:4] NVM_REQ_O && NVM_CMD_O.op inside {NVM_ERASE_EE, NVM_CLEAR_LOCK}; endsequence
    property p_oe; OUTPUT_ENABLE_N_I [*4] |-> !DATA_OE_O; endproperty
    a_oe: assert property (p_oe) else $error("bus driven while disabled");
    property p_pm; !PROG_MODE_O [*2] |-> !DATA_OE_O; endproperty
    a_pm: assert property (p_pm) else $error("bus driven outside mode");
    property p_hold; NVM_REQ_O && !NVM_ACK_I |=> NVM_REQ_O && $stable(NVM_CMD_O); endproperty
    a_hold: assert property (p_hold) else $error("request not held");
    property p_busy; NVM_REQ_O && NVM_CMD_O.op inside {NVM_ERASE_FLASH, NVM_WRITE_FLASH}
        |-> !READY_BUSY_FLAG_O; endproperty
    a_busy: assert property (p_busy) else $error("ready during operation");
    property p_lock; $rose(NVM_REQ_O) && NVM_CMD_O.op == NVM_CLEAR_LOCK
        |-> last_op inside {NVM_ERASE_FLASH, NVM_ERASE_EE}; endproperty
    a_lock: assert property (p_lock) else $error("lock cleared early");
    property p_keep; NVM_REQ_O && NVM_CMD_O.op == NVM_ERASE_EE |-> !KEEP_EEPROM_FUSE_I; endproperty
    a_keep: assert property (p_keep) else $error("kept memory erased");
    property p_seq; NVM_ACK_I && NVM_CMD_O.op == NVM_ERASE_FLASH |-> s_next; endproperty
    a_seq: assert property (p_seq) else $error("erase sequence broken");
    property p_done; NVM_ACK_I && NVM_CMD_O.op == NVM_CLEAR_LOCK |-> ##[1:3] READY_BUSY_FLAG_O;
    endproperty
    a_done: assert property (p_done) else $error("ready late after erase");
    property p_wr; $fell(READY_BUSY_FLAG_O) |-> !$past(WRITE_STROBE_N_I, 3); endproperty
    a_wr: assert property (p_wr) else $error("busy without write pulse");
endmodule // ppp_port_monitor
bind ppp_port ppp_port_monitor u_mon (.CLK_I, .NRST_I, .WRITE_STROBE_N_I, .OUTPUT_ENABLE_N_I,
    .KEEP_EEPROM_FUSE_I, .DATA_OE_O, .READY_BUSY_FLAG_O, .PROG_MODE_O, .NVM_REQ_O, .NVM_CMD_O,
    .NVM_ACK_I);

// >>> ppp_nvm_model.sv
// Purpose: Memory array model behind the request port.
// Assumes: Only flash is stored; erased words read as all ones.
// Notes:   Read data toggle between answers so stale values are not trusted.
`timescale 1ns/1ps
module ppp_nvm_model #(
    parameter int DLY = 2
) (
    input  wire logic                  clk_i,
    input  wire logic                  req_i,
    input  wire ppp_pkg::ppp_nvm_req_t cmd_i,
    output logic                       ack_o = 1'b0,
    output logic [15:0]                rdata_o = 16'h0000
);
    import ppp_pkg::*;
    logic [15:0] mem [int];
    int          n_op [16];
    int          w = 0;
    always @(posedge clk_i) begin
        ack_o   <= 1'b0;
        rdata_o <= ~rdata_o;
        w       <= (req_i && !ack_o) ? w + 1 : 0;
        if (req_i && !ack_o && w == DLY) begin
            ack_o <= 1'b1;
            n_op[cmd_i.op]++;
            if (cmd_i.op == NVM_ERASE_FLASH) mem.delete();
            if (cmd_i.op == NVM_WRITE_FLASH) mem[int'(cmd_i.addr)] = cmd_i.wdata;
            rdata_o <= mem.exists(int'(cmd_i.addr)) ? mem[int'(cmd_i.addr)] : 16'hffff;
        end
    end
endmodule // ppp_nvm_model

// >>> tb_parallel_program_port.sv
// Purpose: Self-checking bench for the programming port.
// Assumes: Pins change at falling clock edges.
// Notes:   Pulses span several clocks to clear the pin synchronisers.
`timescale 1ns/1ps
module tb_parallel_program_port;
    import ppp_pkg::*;
    logic clk = 0, nrst = 0, hv = 0, sclk = 0, wr_n = 1, oe_n = 1, pl = 0, keep = 0;
    logic [1:0] xa = 2'b11, bs = 2'b00;
    logic [7:0] din = 8'h00, dout, fz [4] = '{8'h3c, 8'hc3, 8'h5a, 8'ha5};
    logic doe, rdy, pm, req, ack;
    logic [15:0] rd;
    ppp_nvm_req_t cmd;
    int fail_count = 0, checks_done = 0;
    localparam int CMD_WAIT_CYC = 50000 / CLK_PERIOD_NS;
    always #20 clk = ~clk;
    ppp_port u_dut (.CLK_I(clk), .NRST_I(nrst), .HV_RESET_I(hv), .STROBE_CLK_I(sclk),
        .WRITE_STROBE_N_I(wr_n), .OUTPUT_ENABLE_N_I(oe_n), .PAGE_LATCH_I(pl),
        .STROBE_ACTION_BIT0_I(xa[0]), .STROBE_ACTION_BIT1_I(xa[1]), .BYTE_SELECT_LO_BIT_I(bs[0]),
        .BYTE_SELECT_HI_BIT_I(bs[1]), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(doe),
        .READY_BUSY_FLAG_O(rdy), .PROG_MODE_O(pm), .FUSE_LOW_I(fz[0]), .LOCK_I(fz[1]),
        .FUSE_EXT_I(fz[2]), .FUSE_HIGH_I(fz[3]), .KEEP_EEPROM_FUSE_I(keep), .NVM_REQ_O(req),
        .NVM_CMD_O(cmd), .NVM_ACK_I(ack), .NVM_RDATA_I(rd));
    ppp_nvm_model #(.DLY(2)) u_nvm (.clk_i(clk), .req_i(req), .cmd_i(cmd), .ack_o(ack),
        .rdata_o(rd));
    task automatic wt(input int n); repeat (n) @(negedge clk); endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ld(input logic [1:0] a, b, input logic [7:0] d);
        xa = a; bs = b; din = d; wt(5); sclk = 1; wt(8); sclk = 0; wt(5);
    endtask
    // Busy is sampled at the end of the pulse, just before release, well after the synchroniser delay.
    task automatic wr;
        bs = SEL_LOW; wt(5); wr_n = 0; wt(7);
        chk("busy", 8'h00, {7'h0, rdy});
        wr_n = 1;
        for (int i = 0; i < 3000 && rdy !== 1'b1; i++) wt(1);
        chk("ready", 8'h01, {7'h0, rdy});
    endtask
    task automatic rdb(input logic [1:0] b, input logic [7:0] e);
        bs = b; wt(5); oe_n = 0; wt(16);
        chk("data", e, dout);
        chk("drive", 8'h01, {7'h0, doe});
        oe_n = 1; wt(5);
        chk("release", 8'h00, {7'h0, doe});
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin #2000000; fail_count++; summarize; end
    // A pattern change inside the hold must refuse entry; only a clean second try enters.
    task automatic t_entry;
        chk("ready", 8'h01, {7'h0, rdy});
        repeat (6) begin
            sclk = ~sclk;
            wt(7);
        end
        xa = 2'b00; wt(4); hv = 1; wt(1); xa = 2'b11; wt(12);
        chk("abort", 8'h00, {7'h0, pm});
        hv = 0; xa = 2'b00; wt(6); hv = 1; wt(12);
        chk("mode", 8'h01, {7'h0, pm});
        wt(CMD_WAIT_CYC);
        $display("test entry done");
    endtask
    task automatic t_erase;
        ld(ACT_CMD, SEL_LOW, CMD_CHIP_ERASE);
        wr;
        chk("erase_ee", 8'h01, 8'(u_nvm.n_op[NVM_ERASE_EE]));
        keep = 1;
        wr;
        chk("erase_ee", 8'h01, 8'(u_nvm.n_op[NVM_ERASE_EE]));
        chk("clear_lock", 8'h02, 8'(u_nvm.n_op[NVM_CLEAR_LOCK]));
        $display("test erase done");
    endtask
    // After the no-operation command a write strobe must not start a page again.
    task automatic t_flash;
        ld(ACT_CMD, SEL_LOW, CMD_WRITE_FLASH);
        ld(ACT_ADDR, SEL_LOW, 8'h85);
        ld(ACT_DATA, SEL_LOW, 8'h34);
        ld(ACT_DATA, SEL_HIGH, 8'h12);
        pl = 1; wt(8); pl = 0; wt(5);
        wr;
        ld(ACT_CMD, SEL_LOW, CMD_NOP);
        ld(ACT_CMD, SEL_LOW, CMD_WRITE_FLASH);
        bs = SEL_LOW; wt(5); wr_n = 0; wt(7); wr_n = 1; wt(5);
        chk("page_words", 8'h80, 8'(u_nvm.n_op[NVM_WRITE_FLASH]));
        ld(ACT_CMD, SEL_LOW, CMD_READ_FLASH);
        rdb(SEL_LOW, 8'h34);
        rdb(SEL_HIGH, 8'h12);
        $display("test flash done");
    endtask
    task automatic t_ee;
        ld(ACT_CMD, SEL_LOW, CMD_WRITE_EE);
        ld(ACT_DATA, SEL_LOW, 8'h5a);
        pl = 1; wt(8); pl = 0; wt(5);
        wr;
        chk("ee_page", 8'h08, 8'(u_nvm.n_op[NVM_WRITE_EE]));
        $display("test eeprom done");
    endtask
    task automatic t_fuse;
        ld(ACT_CMD, SEL_LOW, CMD_READ_FUSE);
        for (int i = 0; i < 4; i++) rdb(2'(i), fz[i]);
        $display("test fuse read done");
    endtask
    initial begin
        wt(2); nrst = 1; wt(4);
        t_entry;
        t_erase;
        t_flash;
        t_ee;
        t_fuse;
        summarize;
    end
endmodule // tb_parallel_program_port
